// File: rtl/charge_port_pkg.sv
// charge_port_pkg: pin codes, register map, timing counts
// assumes one free-running 40 MHz clock for the whole block
`default_nettype none
package charge_port_pkg;
  // ********
  // clock and times (ms or ns)
  // ********
  localparam logic [63:0] CLK_KHZ     = 64'h9c40;
  localparam logic [63:0] FS_QUAL_MS  = 64'hea60;
  localparam logic [63:0] LOW_QUAL_MS = 64'h3a98;
  localparam logic [63:0] DISCH_MS    = 64'h7d0;
  localparam logic [63:0] GONE_NS     = 64'h9c4;
  localparam logic [63:0] FS_QUAL_CYC  = FS_QUAL_MS * CLK_KHZ;
  localparam logic [63:0] LOW_QUAL_CYC = LOW_QUAL_MS * CLK_KHZ;
  localparam logic [63:0] DISCH_CYC    = DISCH_MS * CLK_KHZ;
  localparam logic [7:0]  GONE_CYC     =
    8'((GONE_NS * CLK_KHZ + 64'hf423f) / 64'hf4240);
  // ********
  // mode pin codes, {a,b,c}
  // ********
  localparam logic [2:0] CODE_CDP           = 3'h7;
  localparam logic [2:0] CODE_AUTO_CHARGE   = 3'h3;
  localparam logic [2:0] CODE_STD_FIRST     = 3'h2;
  localparam logic [2:0] CODE_STD_FIRST_ALT = 3'h6;
  localparam logic [2:0] CODE_DEEP_SLEEP    = 3'h1;
  localparam logic       SEL_DEEP_SLEEP     = 1'h1;
  // ********
  // register map
  // ********
  localparam logic [3:0] ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ADDR_EVENTS = 4'h4;
  localparam logic [3:0] ADDR_MASK   = 4'h8;
  localparam logic [3:0] ADDR_STATE  = 4'hc;
  localparam logic [1:0] CTRL_RESET  = 2'h3;
  localparam int CTRL_SUPPLY_BIT = 0;
  localparam int CTRL_OVR_BIT    = 1;
  localparam int NUM_EV          = 7;
  localparam logic [6:0] MASK_RESET = 7'h00;
  localparam int EV_OVERRIDE   = 0;
  localparam int EV_LS         = 1;
  localparam int EV_FS         = 2;
  localparam int EV_HS         = 3;
  localparam int EV_ST_ASSERT  = 4;
  localparam int EV_ST_RELEASE = 5;
  localparam int EV_MODE_DISCH = 6;
  // attach class, also the line classifier state
  typedef enum logic [2:0] {CLS_NONE, CLS_LS, CLS_FS_PEND, CLS_FS, CLS_HS} class_t;
endpackage
`default_nettype wire

// File: rtl/line_classifier.sv
// line_classifier: low/full/high speed attach recognition on the data lines
// assumes dp_i, dm_i already synchronised; en_i from same clock
`default_nettype none
module line_classifier #(
  parameter logic [31:0] fs_qual_p = 32'(charge_port_pkg::FS_QUAL_CYC)
) (
  input  wire logic               clk_i,
  input  wire logic               resetn_i,
  input  wire logic               en_i,
  input  wire logic               dp_i,
  input  wire logic               dm_i,
  output var charge_port_pkg::class_t class_o
);
  import charge_port_pkg::*;
  class_t      st_ff;
  logic [31:0] cnt_ff;
  logic [7:0]  gone_ff;
  logic        gone;
  assign gone    = gone_ff == GONE_CYC;
  assign class_o = st_ff;

  // both lines low long enough: unplugged, short eop ignored
  always_ff @(posedge clk_i) begin
    if (!resetn_i || dp_i || dm_i) gone_ff <= 8'h0;
    else if (!gone) gone_ff <= gone_ff + 8'h1;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || st_ff != CLS_FS_PEND) cnt_ff <= 32'h0;
    else cnt_ff <= cnt_ff + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || !en_i) begin
      st_ff <= CLS_NONE;
    end else begin
      unique case (st_ff)
        CLS_NONE: begin
          if (dm_i) st_ff <= CLS_LS;
          else if (dp_i) st_ff <= CLS_FS_PEND;
        end
        CLS_LS, CLS_FS: if (gone) st_ff <= CLS_NONE;
        CLS_FS_PEND: begin
          if (!dp_i) st_ff <= CLS_HS;
          else if (cnt_ff == fs_qual_p - 32'h1) st_ff <= CLS_FS;
        end
        CLS_HS: st_ff <= CLS_HS;
      endcase
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  a_line_gate: assert property (!en_i |=> class_o == CLS_NONE)
    else $error("classifier active outside data modes");
  a_ls_class: assert property ((en_i && class_o == CLS_NONE && dm_i) |=> class_o == CLS_LS)
    else $error("d- high not taken as low speed");
  a_hs_memo: assert property ((en_i && class_o == CLS_FS_PEND && !dp_i) |=> class_o == CLS_HS)
    else $error("d+ fall not memorised");
  a_fs_qual: assert property ((class_o == CLS_FS && $past(class_o) == CLS_FS_PEND)
    |-> $past(cnt_ff) == fs_qual_p - 32'h1)
    else $error("full speed qualified early");
endmodule // line_classifier
`default_nettype wire

// File: rtl/load_detect.sv
// load_detect: deep-sleep load detection driving the supply select
// assumes low_i, limit_i already synchronised comparator levels
`default_nettype none
module load_detect #(
  parameter logic [31:0] low_qual_p = 32'(charge_port_pkg::LOW_QUAL_CYC),
  parameter logic [31:0] disch_p    = 32'(charge_port_pkg::DISCH_CYC)
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic en_i,
  input  wire logic low_i,
  input  wire logic limit_i,
  output logic      status_n_o,
  output logic      low_limit_o,
  output logic      disch_o
);
  import charge_port_pkg::*;
  typedef enum logic [1:0] {L_OFF, L_CHARGE, L_LOW, L_DISCH} load_state_t;
  load_state_t st_ff;
  load_state_t nxt_st;
  logic [31:0] cnt_ff;
  logic        low_done;
  logic        disch_done;
  assign low_done   = low_i && (cnt_ff == low_qual_p - 32'h1);
  assign disch_done = cnt_ff == disch_p - 32'h1;

  always_comb begin
    nxt_st = st_ff;
    if (!en_i) begin
      nxt_st = L_OFF;
    end else begin
      unique case (st_ff)
        L_OFF:    nxt_st = L_CHARGE;
        L_CHARGE: if (low_done) nxt_st = L_LOW;
        L_LOW:    if (limit_i) nxt_st = L_DISCH;
        L_DISCH:  if (disch_done) nxt_st = L_CHARGE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i || nxt_st != st_ff) cnt_ff <= 32'h0;
    else if (st_ff == L_CHARGE && !low_i) cnt_ff <= 32'h0;
    else if (st_ff != L_LOW) cnt_ff <= cnt_ff + 32'h1;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      st_ff       <= L_OFF;
      status_n_o  <= 1'h1;
      low_limit_o <= 1'h0;
      disch_o     <= 1'h0;
    end else begin
      st_ff <= nxt_st;
      status_n_o <= !(nxt_st == L_CHARGE || nxt_st == L_DISCH);
      low_limit_o <= nxt_st == L_LOW;
      disch_o <= nxt_st == L_DISCH;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  sequence s_limit_hit;
    en_i && st_ff == L_LOW && limit_i;
  endsequence
  sequence s_disch_start;
    !status_n_o && disch_o && !low_limit_o;
  endsequence
  a_status_charge: assert property (st_ff == L_CHARGE |-> !status_n_o)
    else $error("status high while charging");
  a_low_entry: assert property ((en_i && st_ff == L_CHARGE && low_done) |=> status_n_o && low_limit_o)
    else $error("low power not entered after quiet period");
  a_reassert: assert property (s_limit_hit |=> s_disch_start)
    else $error("limit hit did not reassert status");
  a_disch_hold: assert property ((disch_o && en_i && !disch_done) |=> disch_o)
    else $error("discharge cut short");
  a_disch_end: assert property ((en_i && st_ff == L_DISCH && disch_done)
    |=> !disch_o && !status_n_o && !low_limit_o)
    else $error("no high limit restart after discharge");
  a_qual_restart: assert property ((en_i && st_ff == L_CHARGE && !low_i) |=> cnt_ff == 32'h0)
    else $error("quiet timer not restarted");
endmodule // load_detect
`default_nettype wire

// File: rtl/charge_port_wake_load_detect.sv
// charge_port_wake_load_detect: mode pin tracking with wake override,
// data line attach recognition, deep-sleep load detect, wishbone registers
// assumes one free-running 40 MHz clock; all pin inputs are asynchronous
//
// Overview of operation
// - 111 to 011: keep data mode
// - 010 to 011: keep data mode
// - intermediate 111 obeyed, output discharged
// - watch data lines only in sdp/cdp
// - d+ falling after connect means high speed
// - full speed wake only after 60 s
// - return from 011 accepted any time
// - deep sleep: status low while charging
// - below 45 ma 15 s: release status
// - over 55 ma in low power: reassert
// - discharge 2 s, then high limit
//
// The register addresses and the Wishbone slave port were left to the implementer.
`default_nettype none
module charge_port_wake_load_detect #(
  parameter logic [31:0] fs_qual_p  = 32'(charge_port_pkg::FS_QUAL_CYC),
  parameter logic [31:0] low_qual_p = 32'(charge_port_pkg::LOW_QUAL_CYC),
  parameter logic [31:0] disch_p    = 32'(charge_port_pkg::DISCH_CYC)
) (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        mode_pin_a_i,
  input  wire logic        mode_pin_b_i,
  input  wire logic        mode_pin_c_i,
  input  wire logic        limit_select_pin_i,
  input  wire logic        dp_i,
  input  wire logic        dm_i,
  input  wire logic        load_low_i,
  input  wire logic        limit_hit_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  output logic             supply_select_wake_n_o,
  output logic             low_limit_o,
  output logic             out_discharge_o,
  output logic [2:0]       mode_code_o,
  output logic             wake_hold_o,
  output logic             ls_wake_o,
  output logic             fs_wake_o,
  output logic             hs_seen_o
);
  import charge_port_pkg::*;

  // ********
  // pin synchronisers
  // ********
  logic [7:0] meta_ff;
  logic [7:0] pin_ff;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      meta_ff <= 8'h00;
      pin_ff  <= 8'h00;
    end else begin
      meta_ff <= {load_low_i, limit_hit_i, dm_i, dp_i,
                  limit_select_pin_i, mode_pin_a_i, mode_pin_b_i, mode_pin_c_i};
      pin_ff  <= meta_ff;
    end
  end

  logic [2:0] code;
  logic       sel;
  assign code = pin_ff[2:0];
  assign sel  = pin_ff[3];

  // ********
  // registers seen by the bus
  // ********
  logic [1:0]        ctrl_ff;
  logic [NUM_EV-1:0] mask_ff;
  logic [NUM_EV-1:0] sts_ff;
  logic [NUM_EV-1:0] ev;
  logic              irq_ff;
  logic              ack_ff;
  logic [31:0]       dat_ff;

  // ********
  // mode pin tracking and wake override
  // ********
  logic [2:0] prev_code_ff;
  logic [2:0] held_code_ff;
  logic [2:0] eff_code_ff;
  logic [2:0] nxt_eff_code;
  logic       hold_ff;
  logic       ovr_trig;
  logic       cdp_entry;
  logic       deep_sleep;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) prev_code_ff <= 3'h0;
    else prev_code_ff <= code;
  end

  // from cdp or first standard code, select pin ignored
  // the two-pin 110 move is not caught here
  assign ovr_trig = ctrl_ff[CTRL_OVR_BIT] && (code == CODE_AUTO_CHARGE) &&
                    ((prev_code_ff == CODE_CDP) ||
                     (prev_code_ff == CODE_STD_FIRST));

  // any arrival at 111 is a real command
  assign cdp_entry = (code == CODE_CDP) && (prev_code_ff != CODE_CDP);

  assign deep_sleep = (code == CODE_DEEP_SLEEP) && (sel == SEL_DEEP_SLEEP);

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hold_ff      <= 1'h0;
      held_code_ff <= 3'h0;
    end else if (ovr_trig) begin
      hold_ff      <= 1'h1;
      held_code_ff <= prev_code_ff;
    end else if (code != CODE_AUTO_CHARGE) begin
      // no deadline, any leave ends hold
      hold_ff      <= 1'h0;
    end
  end

  always_comb begin
    nxt_eff_code = code;
    if (ovr_trig) nxt_eff_code = prev_code_ff;
    else if (hold_ff && code == CODE_AUTO_CHARGE) nxt_eff_code = held_code_ff;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) eff_code_ff <= 3'h0;
    else eff_code_ff <= nxt_eff_code;
  end

  // ********
  // discharge on cdp entry
  // ********
  logic        mdis_ff;
  logic [31:0] mdis_cnt_ff;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      mdis_ff     <= 1'h0;
      mdis_cnt_ff <= 32'h0;
    end else if (cdp_entry) begin
      mdis_ff     <= 1'h1;
      mdis_cnt_ff <= 32'h0;
    end else if (mdis_ff) begin
      mdis_ff     <= mdis_cnt_ff != disch_p - 32'h1;
      mdis_cnt_ff <= mdis_cnt_ff + 32'h1;
    end
  end

  // ********
  // data line watch
  // ********
  logic   mon_en_ff;
  class_t cls;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) mon_en_ff <= 1'h0;
    else mon_en_ff <= (nxt_eff_code == CODE_CDP) ||
                      (nxt_eff_code == CODE_STD_FIRST) ||
                      (nxt_eff_code == CODE_STD_FIRST_ALT);
  end

  line_classifier #(
    .fs_qual_p (fs_qual_p)
  ) u_line (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .en_i     (mon_en_ff),
    .dp_i     (pin_ff[4]),
    .dm_i     (pin_ff[5]),
    .class_o  (cls)
  );

  logic ls_ff;
  logic fs_ff;
  logic hs_ff;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ls_ff <= 1'h0;
      fs_ff <= 1'h0;
      hs_ff <= 1'h0;
    end else begin
      ls_ff <= cls == CLS_LS;
      fs_ff <= cls == CLS_FS;
      hs_ff <= cls == CLS_HS;
    end
  end

  // ********
  // deep sleep load detect
  // ********
  logic ld_en_ff;
  logic ld_status_n;
  logic ld_low_limit;
  logic ld_disch;
  logic stat_prev_ff;
  logic disch_ff;

  // only in deep sleep, gated by software
  always_ff @(posedge clk_i) begin
    if (!resetn_i) ld_en_ff <= 1'h0;
    else ld_en_ff <= deep_sleep && ctrl_ff[CTRL_SUPPLY_BIT];
  end

  load_detect #(
    .low_qual_p (low_qual_p),
    .disch_p    (disch_p)
  ) u_load (
    .clk_i       (clk_i),
    .resetn_i    (resetn_i),
    .en_i        (ld_en_ff),
    .low_i       (pin_ff[7]),
    .limit_i     (pin_ff[6]),
    .status_n_o  (ld_status_n),
    .low_limit_o (ld_low_limit),
    .disch_o     (ld_disch)
  );

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      stat_prev_ff <= 1'h1;
      disch_ff     <= 1'h0;
    end else begin
      stat_prev_ff <= ld_status_n;
      disch_ff     <= mdis_ff || ld_disch;
    end
  end

  // ********
  // events and interrupt
  // ********
  always_comb begin
    ev                = {NUM_EV{1'h0}};
    ev[EV_OVERRIDE]   = ovr_trig;
    ev[EV_LS]         = (cls == CLS_LS) && !ls_ff;
    ev[EV_FS]         = (cls == CLS_FS) && !fs_ff;
    ev[EV_HS]         = (cls == CLS_HS) && !hs_ff;
    ev[EV_ST_ASSERT]  = !ld_status_n && stat_prev_ff;
    ev[EV_ST_RELEASE] = ld_status_n && !stat_prev_ff;
    ev[EV_MODE_DISCH] = cdp_entry;
  end

  // ********
  // wishbone slave, one wait state
  // ********
  logic        bus_hit;
  logic        wr_lo;
  logic [31:0] rdata;
  assign bus_hit = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_lo   = bus_hit && wb_we_i && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (!resetn_i) ack_ff <= 1'h0;
    else ack_ff <= bus_hit;
  end

  always_comb begin
    unique case (wb_adr_i)
      ADDR_CTRL:   rdata = {30'h0, ctrl_ff};
      ADDR_EVENTS: rdata = {25'h0, sts_ff};
      ADDR_MASK:   rdata = {25'h0, mask_ff};
      ADDR_STATE:  rdata = {18'h0, disch_ff, ld_low_limit, ld_status_n, cls,
                            hold_ff, eff_code_ff, sel, code};
      default:     rdata = 32'h0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) dat_ff <= 32'h0;
    else if (bus_hit && !wb_we_i) dat_ff <= rdata;
    else dat_ff <= 32'h0;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      ctrl_ff <= CTRL_RESET;
      mask_ff <= MASK_RESET;
    end else if (wr_lo && wb_adr_i == ADDR_CTRL) begin
      ctrl_ff <= wb_dat_i[1:0];
    end else if (wr_lo && wb_adr_i == ADDR_MASK) begin
      mask_ff <= wb_dat_i[NUM_EV-1:0];
    end
  end

  // read clears; a same-cycle event survives
  always_ff @(posedge clk_i) begin
    if (!resetn_i) sts_ff <= {NUM_EV{1'h0}};
    else if (bus_hit && !wb_we_i && wb_adr_i == ADDR_EVENTS) sts_ff <= ev;
    else sts_ff <= sts_ff | ev;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) irq_ff <= 1'h0;
    else irq_ff <= |(sts_ff & mask_ff);
  end

  // ********
  // outputs
  // ********
  // the system switches supplies on this level
  assign supply_select_wake_n_o = ld_status_n;
  assign low_limit_o            = ld_low_limit;
  assign out_discharge_o        = disch_ff;
  assign mode_code_o            = eff_code_ff;
  assign wake_hold_o            = hold_ff;
  assign ls_wake_o              = ls_ff;
  assign fs_wake_o              = fs_ff;
  assign hs_seen_o              = hs_ff;
  assign irq_o                  = irq_ff;
  assign wb_ack_o               = ack_ff;
  assign wb_dat_o               = dat_ff;

  // ********
  // checks
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_from_cdp;
    ctrl_ff[CTRL_OVR_BIT] && code == CODE_AUTO_CHARGE && prev_code_ff == CODE_CDP;
  endsequence
  sequence s_from_first;
    ctrl_ff[CTRL_OVR_BIT] && code == CODE_AUTO_CHARGE && prev_code_ff == CODE_STD_FIRST;
  endsequence

  a_ovr_from_cdp: assert property (s_from_cdp |=> hold_ff && mode_code_o == CODE_CDP)
    else $error("cdp to auto not overridden");
  a_ovr_from_first: assert property (s_from_first |=> hold_ff && mode_code_o == CODE_STD_FIRST)
    else $error("first standard to auto not overridden");
  a_cdp_disch: assert property (cdp_entry |-> ##2 out_discharge_o)
    else $error("entry to 111 without discharge");
  a_hold_release: assert property ((hold_ff && code != CODE_AUTO_CHARGE)
    |=> !hold_ff && mode_code_o == $past(code))
    else $error("return from auto not followed");
  a_bus_ack: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  a_irq_level: assert property ((|(sts_ff & mask_ff)) |=> irq_o)
    else $error("unmasked event without interrupt");
endmodule // charge_port_wake_load_detect
`default_nettype wire

// File: verification/system_ctrl_model.sv
// system_ctrl_model: system controller on the far side of the port
// assumes one clock shared with the port; drives mode pins, reads status
`default_nettype none
module system_ctrl_model (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [2:0] req_code_i,
  input  wire logic       status_n_i,
  output logic            mode_pin_a_o,
  output logic            mode_pin_b_o,
  output logic            mode_pin_c_o,
  output logic            hp_en_o,
  output logic            lp_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] code_ff;
  // ********
  // mode pins
  // ********
  // no direct 110 to 011 two-pin move
  // a 110 to 011 request steps through 010 so the port never sees 111
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      code_ff <= 3'h0;
    end else if (code_ff == 3'h6 && req_code_i == 3'h3) begin
      code_ff <= 3'h2;
    end else begin
      code_ff <= req_code_i;
    end
  end
  assign {mode_pin_a_o, mode_pin_b_o, mode_pin_c_o} = code_ff;
  assign hp_en_o = !status_n_i;
  assign lp_en_o = status_n_i;
endmodule // system_ctrl_model
`default_nettype wire

// File: verification/charge_port_wake_load_detect_test.sv
// charge_port_wake_load_detect_test: self-checking bench of the port logic
// assumes system_ctrl_model drives the mode pins; long times shortened by parameters
`default_nettype none
module charge_port_wake_load_detect_test;
  timeunit 1ns;
  timeprecision 1ps;
  import charge_port_pkg::*;
  localparam int FSQ = 200;
  localparam int LQ  = 50;
  localparam int DQ  = 20;
  logic        clk_i, resetn_i, limit_select_pin_i, dp_i, dm_i, load_low_i, limit_hit_i;
  logic        mode_pin_a_i, mode_pin_b_i, mode_pin_c_i, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [3:0]  wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q, r;
  logic        wb_ack_o, irq_o, supply_select_wake_n_o, low_limit_o, out_discharge_o;
  logic        wake_hold_o, ls_wake_o, fs_wake_o, hs_seen_o;
  logic [2:0]  mode_code_o, req_code;
  int          bad_count, checks_done, brk;
  int          prev_q[$];
  // ********
  // design and system model
  // ********
  charge_port_wake_load_detect #(.fs_qual_p(FSQ), .low_qual_p(LQ), .disch_p(DQ)) u_charge_port_wake_load_detect (
    .clk_i, .resetn_i, .mode_pin_a_i, .mode_pin_b_i, .mode_pin_c_i, .limit_select_pin_i,
    .dp_i, .dm_i, .load_low_i, .limit_hit_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .supply_select_wake_n_o,
    .low_limit_o, .out_discharge_o, .mode_code_o, .wake_hold_o, .ls_wake_o, .fs_wake_o,
    .hs_seen_o);
  system_ctrl_model u_system_ctrl_model (
    .clk_i, .resetn_i, .req_code_i(req_code), .status_n_i(supply_select_wake_n_o),
    .mode_pin_a_o(mode_pin_a_i), .mode_pin_b_o(mode_pin_b_i), .mode_pin_c_o(mode_pin_c_i),
    .hp_en_o(), .lp_en_o());
  // ********
  // helpers
  // ********
  task automatic report_and_stop();
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // one classic cycle; no answer latency assumed, only the watchdog cuts a hang
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask
  task automatic setc(input logic [2:0] c);
    @(posedge clk_i);
    req_code <= c;
    step(6);
  endtask
  // expected effective code after a move to 011; the model splits 110 into 010
  function automatic logic [2:0] exp_code(input int p);
    return (p == 7 || p == 2 || p == 6) ? ((p == 6) ? 3'h2 : 3'(p)) : CODE_AUTO_CHARGE;
  endfunction
  // ********
  // clock, reset, watchdog
  // ********
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    step(20000);
    $display("CHECK FAILED run_time expected done seen timeout");
    bad_count++;
    report_and_stop();
  end
  // ********
  // scenarios
  // ********
  initial begin
    {resetn_i, limit_select_pin_i, dp_i, dm_i, load_low_i, limit_hit_i} = 6'h00;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, req_code} = '0;
    wb_sel_i = 4'h0;
    bad_count = 0;
    checks_done = 0;
    void'($urandom(32'h148d));
    step(8);
    resetn_i <= 1'b1;
    check("status_rst", 32'h1, {31'h0, supply_select_wake_n_o});
    wb(1'b0, ADDR_CTRL, 32'h0);
    check("ctrl_rst", {30'h0, CTRL_RESET}, q);
    wb(1'b0, 4'h2, 32'h0);
    check("unmapped", 32'h0, q);
    r = $urandom;
    wb(1'b1, ADDR_MASK, r);
    wb(1'b0, ADDR_MASK, 32'h0);
    check("mask", r & 32'h7f, q);
    prev_q = '{7, 2, 6, 1};
    foreach (prev_q[i]) begin
      setc(3'(prev_q[i]));
      check("disch", {31'h0, prev_q[i] == 7}, {31'h0, out_discharge_o});
      setc(CODE_AUTO_CHARGE);
      check("hold", {31'h0, exp_code(prev_q[i]) != 3'h3}, {31'h0, wake_hold_o});
      check("code", {29'h0, exp_code(prev_q[i])}, {29'h0, mode_code_o});
      step(300);
      setc(CODE_STD_FIRST);
      check("hold_end", 32'h0, {31'h0, wake_hold_o});
      check("code_end", {29'h0, CODE_STD_FIRST}, {29'h0, mode_code_o});
    end
    wb(1'b1, ADDR_MASK, 32'h1 << EV_LS);
    wb(1'b0, ADDR_EVENTS, 32'h0);
    dm_i <= 1'b1;
    step(8);
    check("ls", 32'h1, {31'h0, ls_wake_o});
    check("irq", 32'h1, {31'h0, irq_o});
    wb(1'b0, ADDR_EVENTS, 32'h0);
    check("ev_ls", 32'h1, (q >> EV_LS) & 32'h1);
    step(3);
    check("irq_clr", 32'h0, {31'h0, irq_o});
    dm_i <= 1'b0;
    step(110);
    check("ls_gone", 32'h0, {31'h0, ls_wake_o});
    dp_i <= 1'b1;
    step(FSQ - 10);
    check("fs_early", 32'h0, {31'h0, fs_wake_o});
    step(20);
    check("fs", 32'h1, {31'h0, fs_wake_o});
    dp_i <= 1'b0;
    step(110);
    dp_i <= 1'b1;
    step(20);
    dp_i <= 1'b0;
    step(8);
    check("hs", 32'h1, {31'h0, hs_seen_o});
    check("hs_fs", 32'h0, {31'h0, fs_wake_o});
    limit_select_pin_i <= 1'b1;
    setc(CODE_DEEP_SLEEP);
    dm_i <= 1'b1;
    step(8);
    check("ls_off", 32'h0, {31'h0, ls_wake_o});
    check("charging", 32'h0, {31'h0, supply_select_wake_n_o});
    dm_i <= 1'b0;
    brk = 10 + ($urandom % 30);
    load_low_i <= 1'b1;
    step(brk);
    load_low_i <= 1'b0;
    step(5);
    load_low_i <= 1'b1;
    step(LQ - 5);
    check("restart", 32'h0, {31'h0, supply_select_wake_n_o});
    step(15);
    check("release", 32'h1, {31'h0, supply_select_wake_n_o});
    check("low_lim", 32'h1, {31'h0, low_limit_o});
    load_low_i <= 1'b0;
    limit_hit_i <= 1'b1;
    step(3);
    limit_hit_i <= 1'b0;
    step(4);
    check("reassert", 32'h0, {31'h0, supply_select_wake_n_o});
    check("ld_disch", 32'h1, {31'h0, out_discharge_o});
    step(DQ + 8);
    check("disch_end", 32'h0, {31'h0, out_discharge_o});
    check("high_lim", 32'h0, {31'h0, low_limit_o});
    report_and_stop();
  end
endmodule // charge_port_wake_load_detect_test
`default_nettype wire
